// ### hw/fifo_device_end.sv
`timescale 1ns/1ps
`default_nettype none
// Dual-clock FIFO: write side on link_clk, read side on clk.
module fifo_device_end
	import fifo_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             link_clk,
	input  wire logic             rst_n,
	input  wire logic             ce,
	fifo_link_if.dev              link,
	input  wire logic             empty_offset_wr,
	input  wire logic [OFF_W-1:0] empty_offset_in,
	input  wire logic             full_offset_wr,
	input  wire logic [OFF_W-1:0] full_offset_in,
	output logic      [OFF_W-1:0] empty_offset_out,
	output logic      [OFF_W-1:0] full_offset_out,
	output logic                  fall_through_mode,
	output logic                  serial_load_mode
);
	// Word storage, written on link_clk and read on clk.
	logic [DATA_W-1:0] mem_reg [DEPTH];

	// ---------------- Write domain ----------------
	logic [1:0]       w_strap_s1_reg;  // Strap synchroniser, first stage.
	logic [1:0]       w_strap_s2_reg;  // Strap synchroniser, second stage.
	logic [1:0]       w_wait_reg;      // Edges since reset release.
	logic             w_done_reg;      // Straps latched.
	logic             w_fall_through_mode_reg;      // Fall-through mode in this domain.
	logic             w_serial_reg;    // Serial method chosen.
	logic [OFF_W-1:0] full_off_reg;    // Full offset m.
	logic [PTR_W-1:0] wptr_reg;        // Binary write pointer.
	logic [PTR_W-1:0] wgray_reg;       // Gray write pointer.
	logic [PTR_W-1:0] r2w_s1_reg;      // Read pointer sync, first stage.
	logic [PTR_W-1:0] r2w_s2_reg;      // Read pointer sync, second stage.
	logic             ov_s1_reg;       // Output-register level sync, first stage.
	logic             ov_s2_reg;       // Output-register level sync, second stage.
	logic             full_reg;        // Registered full, gates writes.
	logic             ff_n_reg;        // Full flag pin.
	logic             ir_n_reg;        // Input-ready pin.
	logic             af_n_reg;        // Almost-full pin.
	logic             hf_n_reg;        // Half-full pin.
	logic [PTR_W-1:0] rgray_reg;       // Gray read pointer, owned by the read domain.
	logic             ov_reg;          // Output register holds a word, owned by the read domain.

	wire              w_latch   = ~w_done_reg & (w_wait_reg == STRAP_WAIT);
	wire              w_done_nx = w_done_reg | w_latch;
	wire              wr_go     = w_done_reg & ~link.write_en_n & ~full_reg;
	wire [PTR_W-1:0]  wptr_nx   = wptr_reg + {{(PTR_W-1){1'b0}}, wr_go};
	wire [PTR_W-1:0]  rptr_w    = gray_to_bin(r2w_s2_reg);
	wire [PTR_W-1:0]  mem_cnt_w = wptr_nx - rptr_w;
	// Fall-through counts the word held in the output register as stored.
	wire [PTR_W-1:0]  fall_through_mode_w    = {{(PTR_W-1){1'b0}}, w_fall_through_mode_reg};
	wire [PTR_W-1:0]  cnt_w     = mem_cnt_w + (fall_through_mode_w & {PTR_W{ov_s2_reg}});
	wire [PTR_W-1:0]  cap_w     = DEPTH_WORDS + fall_through_mode_w;
	wire              full_c    = (cnt_w == cap_w) | (mem_cnt_w == DEPTH_WORDS);
	wire              hf_c      = cnt_w > (HALF_WORDS + fall_through_mode_w);
	wire              af_c      = cnt_w >= (cap_w - {1'b0, full_off_reg});
	wire              full_nx   = ~w_done_nx | full_c;

	// Strap capture a few edges after release, from synchronised pins.
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			w_strap_s1_reg <= 2'h0;
			w_strap_s2_reg <= 2'h0;
			w_wait_reg     <= 2'h0;
			w_done_reg     <= 1'b0;
			w_fall_through_mode_reg     <= 1'b0;
			w_serial_reg   <= 1'b0;
		end else if (ce) begin
			w_strap_s1_reg <= {link.mode_select_serial_in, ~link.offset_load_n};
			w_strap_s2_reg <= w_strap_s1_reg;
			w_done_reg     <= w_done_nx;
			if (!w_done_reg) begin
				w_wait_reg <= w_wait_reg + 2'h1;
			end
			if (w_latch) begin
				w_fall_through_mode_reg   <= w_strap_s2_reg[1];
				w_serial_reg <= ~w_strap_s2_reg[0];
			end
		end
	end

	// Full offset: default by method at latch, then user writes at any time.
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			full_off_reg <= PARALLEL_OFFSET;
		end else if (ce) begin
			if (w_latch) begin
				full_off_reg <= w_strap_s2_reg[0] ? PARALLEL_OFFSET : SERIAL_OFFSET;
			end else if (w_done_reg && full_offset_wr) begin
				full_off_reg <= full_offset_in;
			end
		end
	end

	// Memory write, no reset needed on storage.
	always_ff @(posedge link_clk) begin
		if (ce && wr_go) begin
			mem_reg[wptr_reg[ADDR_W-1:0]] <= link.data_in;
		end
	end

	// Pointers, crossings and write-side flags.
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			wptr_reg   <= '0;
			wgray_reg  <= '0;
			r2w_s1_reg <= '0;
			r2w_s2_reg <= '0;
			ov_s1_reg  <= 1'b0;
			ov_s2_reg  <= 1'b0;
			full_reg   <= 1'b1;
			ff_n_reg   <= 1'b0;
			ir_n_reg   <= 1'b1;
			af_n_reg   <= 1'b1;
			hf_n_reg   <= 1'b1;
		end else if (ce) begin
			wptr_reg   <= wptr_nx;
			wgray_reg  <= wptr_nx ^ (wptr_nx >> 1);
			r2w_s1_reg <= rgray_reg;
			r2w_s2_reg <= r2w_s1_reg;
			ov_s1_reg  <= ov_reg;
			ov_s2_reg  <= ov_s1_reg;
			full_reg   <= full_nx;
			ff_n_reg   <= ~full_nx;
			ir_n_reg   <= full_nx;
			af_n_reg   <= ~af_c;
			hf_n_reg   <= ~hf_c;
		end
	end

	// ---------------- Read domain ----------------
	logic [1:0]        r_strap_s1_reg; // Strap synchroniser, first stage.
	logic [1:0]        r_strap_s2_reg; // Strap synchroniser, second stage.
	logic [1:0]        r_wait_reg;     // Edges since reset release.
	logic              r_done_reg;     // Straps latched.
	logic              r_fall_through_mode_reg;     // Fall-through mode in this domain.
	logic [OFF_W-1:0]  empty_off_reg;  // Empty offset n.
	logic [PTR_W-1:0]  rptr_reg;       // Binary read pointer.
	logic [PTR_W-1:0]  w2r_s1_reg;     // Write pointer sync, first stage.
	logic [PTR_W-1:0]  w2r_s2_reg;     // Write pointer sync, second stage.
	logic              emp_reg;        // Memory empty after last edge.
	logic [DATA_W-1:0] dout_reg;       // Output register.
	logic              ef_n_reg;       // Empty flag pin.
	logic              or_n_reg;       // Output-ready pin.
	logic              ae_n_reg;       // Almost-empty pin.

	wire              r_latch   = ~r_done_reg & (r_wait_reg == STRAP_WAIT);
	wire [PTR_W-1:0]  wptr_r    = gray_to_bin(w2r_s2_reg);
	wire              mem_has   = (wptr_r != rptr_reg);
	// Standard read only on request and only while not empty.
	wire              rd_std    = ~r_fall_through_mode_reg & ~link.read_en_n & ~emp_reg;
	// Fall-through consumes the shown word on request.
	wire              rd_user   = r_fall_through_mode_reg & ~link.read_en_n & ov_reg;
	// Output register refills without a request when it is free.
	wire              ld_ov     = r_fall_through_mode_reg & (~ov_reg | rd_user) & mem_has;
	wire              mem_rd    = rd_std | ld_ov;
	wire [PTR_W-1:0]  rptr_nx   = rptr_reg + {{(PTR_W-1){1'b0}}, mem_rd};
	wire              ov_nx     = ld_ov | (ov_reg & ~rd_user);
	wire [PTR_W-1:0]  cnt_r_mem = wptr_r - rptr_nx;
	wire              emp_nx    = (cnt_r_mem == '0);
	wire [PTR_W-1:0]  fall_through_mode_r    = {{(PTR_W-1){1'b0}}, r_fall_through_mode_reg};
	wire [PTR_W-1:0]  cnt_r     = cnt_r_mem + (fall_through_mode_r & {PTR_W{ov_nx}});
	wire              ae_clr    = cnt_r > ({1'b0, empty_off_reg} + fall_through_mode_r);

	// Strap capture and empty offset in the read domain.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r_strap_s1_reg <= 2'h0;
			r_strap_s2_reg <= 2'h0;
			r_wait_reg     <= 2'h0;
			r_done_reg     <= 1'b0;
			r_fall_through_mode_reg     <= 1'b0;
			empty_off_reg  <= PARALLEL_OFFSET;
		end else if (ce) begin
			r_strap_s1_reg <= {link.mode_select_serial_in, ~link.offset_load_n};
			r_strap_s2_reg <= r_strap_s1_reg;
			if (!r_done_reg) begin
				r_wait_reg <= r_wait_reg + 2'h1;
			end
			if (r_latch) begin
				r_done_reg    <= 1'b1;
				r_fall_through_mode_reg    <= r_strap_s2_reg[1];
				empty_off_reg <= r_strap_s2_reg[0] ? PARALLEL_OFFSET : SERIAL_OFFSET;
			end else if (r_done_reg && empty_offset_wr) begin
				empty_off_reg <= empty_offset_in;
			end
		end
	end

	// Read pointer, output register and read-side flags.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rptr_reg   <= '0;
			rgray_reg  <= '0;
			w2r_s1_reg <= '0;
			w2r_s2_reg <= '0;
			emp_reg    <= 1'b1;
			ov_reg     <= 1'b0;
			dout_reg   <= '0;
			ef_n_reg   <= 1'b0;
			or_n_reg   <= 1'b1;
			ae_n_reg   <= 1'b0;
		end else if (ce) begin
			w2r_s1_reg <= wgray_reg;
			w2r_s2_reg <= w2r_s1_reg;
			rptr_reg   <= rptr_nx;
			rgray_reg  <= rptr_nx ^ (rptr_nx >> 1);
			emp_reg    <= emp_nx;
			ov_reg     <= ov_nx;
			if (mem_rd) begin
				dout_reg <= mem_reg[rptr_reg[ADDR_W-1:0]];
			end
			ef_n_reg <= r_fall_through_mode_reg ? ov_nx : ~emp_nx;
			or_n_reg <= r_fall_through_mode_reg ? ~ov_nx : emp_nx;
			ae_n_reg <= ae_clr;
		end
	end

	// Offset read-back is driven in both the parallel and the serial load method.
	assign empty_offset_out    = empty_off_reg;
	assign full_offset_out     = full_off_reg;
	assign fall_through_mode   = r_fall_through_mode_reg;
	assign serial_load_mode    = w_serial_reg;
	assign link.data_out       = dout_reg;
	assign link.full_flag_n    = ff_n_reg;
	assign link.input_ready_n  = ir_n_reg;
	assign link.almost_full_n  = af_n_reg;
	assign link.half_full_n    = hf_n_reg;
	assign link.empty_flag_n   = ef_n_reg;
	assign link.output_ready_n = or_n_reg;
	assign link.almost_empty_n = ae_n_reg;
endmodule : fifo_device_end
`default_nettype wire

// ### hw/fifo_pkg.sv
package fifo_pkg;
	localparam int                 DATA_W          = 9;  // Word width.
	localparam int                 ADDR_W          = 16; // Memory address width.
	localparam int                 PTR_W           = ADDR_W + 1; // Pointer with wrap bit.
	localparam int                 OFF_W           = 16; // Offset register width.
	localparam int                 DEPTH           = 65536; // Memory words.
	localparam logic [PTR_W-1:0]   DEPTH_WORDS     = PTR_W'(DEPTH); // Capacity as a count.
	localparam logic [PTR_W-1:0]   HALF_WORDS      = DEPTH_WORDS >> 1; // Half capacity.
	localparam logic [OFF_W-1:0]   SERIAL_OFFSET   = 16'h03FF; // Default for serial method.
	localparam logic [OFF_W-1:0]   PARALLEL_OFFSET = 16'h007F; // Default for parallel method.
	localparam logic [1:0]         STRAP_WAIT      = 2'h3; // Edges before straps are latched.

	// Converts a gray pointer back to binary.
	function automatic logic [PTR_W-1:0] gray_to_bin(input logic [PTR_W-1:0] g);
		logic [PTR_W-1:0] b;
		b[PTR_W-1] = g[PTR_W-1];
		for (int i = PTR_W - 2; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction : gray_to_bin
endpackage : fifo_pkg

// ### hw/fifo_link_if.sv
`timescale 1ns/1ps
`default_nettype none
// Pins between the FIFO and the writer and reader logic.
interface fifo_link_if;
	import fifo_pkg::*;
	logic              write_en_n;            // Write request, active low.
	logic [DATA_W-1:0] data_in;               // Word to write.
	logic              read_en_n;             // Read request, active low.
	logic [DATA_W-1:0] data_out;              // Word read.
	logic              mode_select_serial_in; // Timing mode strap.
	logic              offset_load_n;         // Offset method strap.
	logic              full_flag_n;           // Low when full.
	logic              input_ready_n;         // High when full.
	logic              empty_flag_n;          // Low when empty.
	logic              output_ready_n;        // High in fall-through when no word shown, in standard mode when empty.
	logic              almost_empty_n;        // Low when nearly empty.
	logic              almost_full_n;         // Low when nearly full.
	logic              half_full_n;           // Low when over half full.

	// The FIFO end.
	modport dev (
		input  write_en_n, data_in, read_en_n, mode_select_serial_in, offset_load_n,
		output data_out, full_flag_n, input_ready_n, empty_flag_n, output_ready_n,
		output almost_empty_n, almost_full_n, half_full_n
	);
	// The writer and reader end.
	modport host (
		output write_en_n, data_in, read_en_n, mode_select_serial_in, offset_load_n,
		input  data_out, full_flag_n, input_ready_n, empty_flag_n, output_ready_n,
		input  almost_empty_n, almost_full_n, half_full_n
	);
endinterface : fifo_link_if
`default_nettype wire

// ### hw/fifo_host_end.sv
`timescale 1ns/1ps
`default_nettype none
// Writer on link_clk and reader on clk, driving the FIFO pins.
module fifo_host_end
	import fifo_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              link_clk,
	input  wire logic              rst_n,
	input  wire logic              ce,
	fifo_link_if.host              link,
	input  wire logic              cfg_fall_through,
	input  wire logic              cfg_serial_load,
	input  wire logic              wr_valid,
	input  wire logic [DATA_W-1:0] wr_data,
	output logic                   wr_ready,
	input  wire logic              rd_ready,
	output logic                   rd_valid,
	output logic      [DATA_W-1:0] rd_data
);
	logic              mode_reg;    // Timing mode strap driven out.
	logic              load_n_reg;  // Method strap driven out.
	logic              hold_reg;    // A word waits for the FIFO.
	logic [DATA_W-1:0] din_reg;     // Word on the data pins.
	logic              wen_n_reg;   // Write enable pin.
	logic              wr_rdy_reg;  // Ready toward the user.
	logic              ren_n_reg;   // Read enable pin.
	logic              pend_reg;    // Standard read awaiting data.
	logic              rvalid_reg;  // Word delivered.
	logic [DATA_W-1:0] rdata_reg;   // Delivered word.

	// The FIFO takes a word exactly when enable is low and it is not full.
	wire taken     = ~wen_n_reg & link.full_flag_n;
	wire accept    = wr_valid & wr_rdy_reg;
	wire hold_nx   = (hold_reg & ~taken) | accept;
	wire std_take  = ~cfg_fall_through & ~ren_n_reg & link.empty_flag_n;
	wire ft_take   = cfg_fall_through & ~ren_n_reg & ~link.output_ready_n;

	// Writer side: straps and one-word hold buffer.
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_reg   <= 1'b0;
			load_n_reg <= 1'b0;
			hold_reg   <= 1'b0;
			din_reg    <= '0;
			wen_n_reg  <= 1'b1;
			wr_rdy_reg <= 1'b0;
		end else if (ce) begin
			mode_reg   <= cfg_fall_through;
			load_n_reg <= cfg_serial_load;
			hold_reg   <= hold_nx;
			wen_n_reg  <= ~hold_nx;
			wr_rdy_reg <= ~hold_nx;
			if (accept) begin
				din_reg <= wr_data;
			end
		end
	end

	// Reader side: request words and deliver them.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ren_n_reg  <= 1'b1;
			pend_reg   <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg  <= '0;
		end else if (ce) begin
			ren_n_reg  <= ~rd_ready;
			pend_reg   <= std_take;
			rvalid_reg <= pend_reg | ft_take;
			if (pend_reg || ft_take) begin
				rdata_reg <= link.data_out;
			end
		end
	end

	assign link.mode_select_serial_in = mode_reg;
	assign link.offset_load_n         = load_n_reg;
	assign link.write_en_n            = wen_n_reg;
	assign link.data_in               = din_reg;
	assign link.read_en_n             = ren_n_reg;
	assign wr_ready                   = wr_rdy_reg;
	assign rd_valid                   = rvalid_reg;
	assign rd_data                    = rdata_reg;
endmodule : fifo_host_end
`default_nettype wire

// ### sim/fifo_link_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the pins between the FIFO end and the writer and reader end.
module fifo_link_assertions
	import fifo_pkg::*;
(
	input wire logic              clk,
	input wire logic              link_clk,
	input wire logic              rst_n,
	input wire logic              write_en_n,
	input wire logic              read_en_n,
	input wire logic [DATA_W-1:0] data_out,
	input wire logic              mode_select_serial_in,
	input wire logic              full_flag_n,
	input wire logic              input_ready_n,
	input wire logic              empty_flag_n,
	input wire logic              output_ready_n,
	input wire logic              almost_empty_n,
	input wire logic              almost_full_n,
	input wire logic              half_full_n
);
	// Input-ready is always the complement of the full flag.
	a_ready_full_inverse: assert property (@(posedge link_clk) disable iff (!rst_n)
		input_ready_n == !full_flag_n) else $error("input ready not inverse of full");
	// Output-ready is always the complement of the empty flag.
	a_ready_empty_inverse: assert property (@(posedge clk) disable iff (!rst_n)
		output_ready_n == !empty_flag_n) else $error("output ready not inverse of empty");
	// A refused read in standard mode leaves the output word alone.
	a_empty_read_holds: assert property (@(posedge clk) disable iff (!rst_n)
		!mode_select_serial_in && !read_en_n && !empty_flag_n |=> $stable(data_out))
		else $error("read while empty changed data");
	// A write refused while full is not lost: the request is held for a retry.
	a_full_write_refused: assert property (@(posedge link_clk) disable iff (!rst_n)
		!full_flag_n && !write_en_n |=> !write_en_n) else $error("refused write dropped");
	// In standard mode only a read can empty the memory.
	a_empty_needs_read: assert property (@(posedge clk) disable iff (!rst_n)
		!mode_select_serial_in && empty_flag_n && read_en_n |=> empty_flag_n)
		else $error("empty without a read");
	// Becoming full means almost-full and half-full are already low.
	a_full_implies_flags: assert property (@(posedge link_clk) disable iff (!rst_n)
		$fell(full_flag_n) |-> !almost_full_n && !half_full_n)
		else $error("full without almost full and half full");
	// Draining to empty brings almost-empty low within two edges.
	a_empty_near_empty: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(empty_flag_n) |-> ##[0:2] !almost_empty_n) else $error("empty but not almost empty");
	// A write taken by the FIFO is not requested again at the next edge.
	a_write_single_pulse: assert property (@(posedge link_clk) disable iff (!rst_n)
		!write_en_n && full_flag_n |=> write_en_n) else $error("taken write requested again");
endmodule : fifo_link_assertions
`default_nettype wire

// ### sim/tb_dual_clock_fifo_flag_modes.sv
`timescale 1ns/1ps
`default_nettype none
// Compares a value with its expectation and counts both outcomes.
`define CHK(what, got, exp) begin \
	checked++; \
	if ((got) !== (exp)) begin \
		mismatches++; \
		$display("unexpected %s expected %h seen %h", what, exp, got); \
	end \
end
// Drives writer and reader user sides of both ends joined by the link.
module tb_dual_clock_fifo_flag_modes
	import fifo_pkg::*;
;
	logic              clk, link_clk, rst_n;             // Clocks and reset.
	logic              empty_offset_wr, full_offset_wr;  // Offset write pulses.
	logic [OFF_W-1:0]  empty_offset_in, full_offset_in;  // Offset values.
	logic [OFF_W-1:0]  empty_offset_out, full_offset_out; // Offset readback.
	logic              fall_through_mode, serial_load_mode; // Latched straps.
	logic              cfg_fall_through, cfg_serial_load;   // Strap choices.
	logic              wr_valid, wr_ready, rd_ready, rd_valid; // User handshakes.
	logic [DATA_W-1:0] wr_data, rd_data;                 // User words.
	int                checked, mismatches;              // Tallies.
	fifo_link_if link();
	fifo_device_end fifo_device_end_inst (.clk(clk), .link_clk(link_clk), .rst_n(rst_n),
		.ce(1'b1), .link(link), .empty_offset_wr(empty_offset_wr),
		.empty_offset_in(empty_offset_in), .full_offset_wr(full_offset_wr),
		.full_offset_in(full_offset_in), .empty_offset_out(empty_offset_out),
		.full_offset_out(full_offset_out), .fall_through_mode(fall_through_mode),
		.serial_load_mode(serial_load_mode));
	fifo_host_end fifo_host_end_inst (.clk(clk), .link_clk(link_clk), .rst_n(rst_n), .ce(1'b1),
		.link(link), .cfg_fall_through(cfg_fall_through), .cfg_serial_load(cfg_serial_load),
		.wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready), .rd_ready(rd_ready),
		.rd_valid(rd_valid), .rd_data(rd_data));
	fifo_link_assertions fifo_link_assertions_inst (.clk(clk), .link_clk(link_clk),
		.rst_n(rst_n), .write_en_n(link.write_en_n), .read_en_n(link.read_en_n),
		.data_out(link.data_out), .mode_select_serial_in(link.mode_select_serial_in),
		.full_flag_n(link.full_flag_n), .input_ready_n(link.input_ready_n),
		.empty_flag_n(link.empty_flag_n), .output_ready_n(link.output_ready_n),
		.almost_empty_n(link.almost_empty_n), .almost_full_n(link.almost_full_n),
		.half_full_n(link.half_full_n));
	// Read clock at 100 ns and a write clock at 32 ns whose rising edges never meet it.
	always #50 clk = ~clk;
	always #16 link_clk = ~link_clk;
	// Waits a number of read clock falling edges.
	task automatic wait_clk(input int n);
		repeat (n) @(negedge clk);
	endtask : wait_clk
	// Holds reset for two cycles with the chosen straps, then lets them latch.
	task automatic do_reset(input logic ft, input logic ser);
		@(negedge clk);
		rst_n = 1'b0;
		cfg_fall_through = ft;
		cfg_serial_load = ser;
		wait_clk(2);
		rst_n = 1'b1;
		wait_clk(10);
	endtask : do_reset
	// Writes n words counting up from base, returning once each has landed in the FIFO.
	task automatic write_words(input int base, input int n);
		int t;
		for (int i = 0; i < n; i++) begin
			@(negedge link_clk);
			wr_data = DATA_W'(base + i);
			wr_valid = 1'b1;
			t = 0;
			while (wr_ready !== 1'b1 && t < 50) begin
				@(negedge link_clk);
				t++;
			end
			`CHK("wr_ready", wr_ready, 1'b1)
			@(posedge link_clk);
			@(negedge link_clk);
			wr_valid = 1'b0;
			// The FIFO takes the presented word at the next edge, so let that edge pass.
			@(negedge link_clk);
		end
	endtask : write_words
	// Reads n words and expects them to count up from base.
	task automatic read_words(input int base, input int n);
		int t;
		rd_ready = 1'b1;
		for (int i = 0; i < n; i++) begin
			t = 0;
			while (rd_valid !== 1'b1 && t < 50) begin
				@(negedge clk);
				t++;
			end
			`CHK("rd_valid", rd_valid, 1'b1)
			`CHK("rd_data", rd_data, DATA_W'(base + i))
			@(negedge clk);
		end
		rd_ready = 1'b0;
	endtask : read_words
	// Programs both offsets and reads them straight back.
	task automatic set_offsets(input logic [OFF_W-1:0] e, input logic [OFF_W-1:0] f);
		empty_offset_in = e;
		empty_offset_wr = 1'b1;
		@(negedge clk);
		empty_offset_wr = 1'b0;
		@(negedge link_clk);
		full_offset_in = f;
		full_offset_wr = 1'b1;
		@(negedge link_clk);
		full_offset_wr = 1'b0;
		wait_clk(1);
		`CHK("empty offset", empty_offset_out, e)
		`CHK("full offset", full_offset_out, f)
	endtask : set_offsets
	// Straps latched at reset choose mode, method and default offsets.
	task automatic test_defaults(input logic ft, input logic ser);
		do_reset(ft, ser);
		`CHK("fall through mode", fall_through_mode, ft)
		`CHK("serial load mode", serial_load_mode, ser)
		`CHK("empty default", empty_offset_out, ser ? SERIAL_OFFSET : PARALLEL_OFFSET)
		`CHK("full default", full_offset_out, ser ? SERIAL_OFFSET : PARALLEL_OFFSET)
		$display("test defaults done");
	endtask : test_defaults
	// Standard mode: words wait for requests, flags follow the count.
	task automatic test_standard();
		do_reset(1'b0, 1'b0);
		set_offsets(16'h0002, 16'h0004);
		write_words(1, 2);
		wait_clk(8);
		`CHK("empty_flag_n", link.empty_flag_n, 1'b1)
		`CHK("data_out unrequested", link.data_out, 9'h000)
		`CHK("almost_empty_n at n", link.almost_empty_n, 1'b0)
		write_words(3, 1);
		wait_clk(8);
		`CHK("almost_empty_n at n+1", link.almost_empty_n, 1'b1)
		read_words(1, 3);
		wait_clk(4);
		`CHK("empty_flag_n drained", link.empty_flag_n, 1'b0)
		rd_ready = 1'b1;
		repeat (5) begin
			@(negedge clk);
			`CHK("rd_valid while empty", rd_valid, 1'b0)
		end
		rd_ready = 1'b0;
		`CHK("data_out while empty", link.data_out, 9'h003)
		$display("test standard done");
	endtask : test_standard
	// Fall-through: the first word shows unasked, later ones on request.
	task automatic test_fall_through();
		int t;
		do_reset(1'b1, 1'b0);
		set_offsets(16'h0002, 16'h0004);
		write_words(5, 1);
		t = 0;
		while (link.output_ready_n !== 1'b0 && t < 20) begin
			@(negedge clk);
			t++;
		end
		`CHK("output_ready_n", link.output_ready_n, 1'b0)
		`CHK("first word shown", link.data_out, 9'h005)
		write_words(6, 2);
		wait_clk(8);
		`CHK("almost_empty_n at n+1", link.almost_empty_n, 1'b0)
		write_words(8, 1);
		wait_clk(8);
		`CHK("almost_empty_n at n+2", link.almost_empty_n, 1'b1)
		read_words(5, 4);
		wait_clk(4);
		`CHK("output_ready_n drained", link.output_ready_n, 1'b1)
		$display("test fall through done");
	endtask : test_fall_through
	// Standard mode filled to capacity with no reads, then one read.
	task automatic test_fill();
		int t;
		do_reset(1'b0, 1'b0);
		set_offsets(16'h0002, 16'h0004);
		for (int i = 1; i <= 65536; i++) begin
			write_words(i, 1);
			if (i == 32768 || i == 32769)
				`CHK("half_full_n", link.half_full_n, 1'(i == 32768))
			if (i == 65531 || i == 65532)
				`CHK("almost_full_n", link.almost_full_n, 1'(i == 65531))
			if (i >= 65535)
				`CHK("full_flag_n", link.full_flag_n, 1'(i == 65535))
		end
		wr_valid = 1'b1;
		repeat (10) begin
			@(negedge link_clk);
			`CHK("wr_ready while full", wr_ready, 1'b0)
			`CHK("full_flag_n while full", link.full_flag_n, 1'b0)
		end
		wr_valid = 1'b0;
		wait_clk(1);
		// One read request; the held word refills the FIFO one edge after full clears.
		rd_ready = 1'b1;
		wait_clk(1);
		rd_ready = 1'b0;
		t = 0;
		while (link.full_flag_n !== 1'b1 && t < 20) begin
			@(negedge link_clk);
			t++;
		end
		`CHK("full_flag_n after read", link.full_flag_n, 1'b1)
		wait_clk(3);
		`CHK("rd_data first word", rd_data, DATA_W'(1))
		`CHK("full_flag_n refilled", link.full_flag_n, 1'b0)
		$display("test fill done");
	endtask : test_fill
	// Prints the tallies and the verdict, then stops.
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run
	// Cuts a hang short well after the tests should have ended.
	initial begin
		#9000000;
		mismatches++;
		complete_run();
	end
	// Main sequence.
	initial begin
		{clk, link_clk, rst_n, wr_valid, rd_ready} = '0;
		{empty_offset_wr, full_offset_wr, cfg_fall_through, cfg_serial_load} = '0;
		{empty_offset_in, full_offset_in, wr_data} = '0;
		checked = 0;
		mismatches = 0;
		for (int k = 0; k < 4; k++)
			test_defaults(k[0], k[1]);
		test_standard();
		test_fall_through();
		test_fill();
		complete_run();
	end
endmodule : tb_dual_clock_fifo_flag_modes
`default_nettype wire
